// ---- hdl/sle_pkg.sv ----
// Purpose: shared constants, carriers and helpers for the serial link
//          error and configuration register pair
// Assumes: one register selected per frame, 7-bit register address
// Notes:   functions here are used by both the datapath and its checks
package sle_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_STATUS  = 7'h11;
  localparam logic [6:0] ADDR_ID      = 7'h12;
  localparam logic [6:0] ADDR_CONFIG  = 7'h14;
  localparam logic [6:0] ADDR_SCRATCH = 7'h18;

  // ----------------------------------------------------------------
  // reset values and frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  CONFIG_RESET  = 8'h04;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'h00;
  localparam logic [7:0]  ID_DEFAULT    = 8'h5A;  // arbitrary identity value

  // ----------------------------------------------------------------
  // timing: interface not ready for a while after reset release
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS = 50;
  localparam int unsigned READY_TIME_NS   = 2000;
  localparam int unsigned READY_CYCLES    =
    (READY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       alert_pullup;
    logic       mem_crc_check;
    logic [1:0] sdo_drive;
    logic       ddr;
  } sle_cfg_t;

  typedef struct packed {
    logic not_ready;
    logic edge_count_fault_flag;
    logic crc_fault;
    logic readonly_write_flag;
    logic partial_access;
    logic invalid_address;
  } sle_stat_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reserved positions are constant zero, never stored
  function automatic logic [7:0] sle_cfg_byte(input sle_cfg_t c);
    sle_cfg_byte = {1'b0, c.alert_pullup, 1'b0, c.mem_crc_check, c.sdo_drive, 1'b0, c.ddr};
  endfunction

  function automatic sle_cfg_t sle_cfg_from(input logic [7:0] b);
    sle_cfg_from = '{alert_pullup: b[6], mem_crc_check: b[4], sdo_drive: b[3:2], ddr: b[0]};
  endfunction

  function automatic logic [7:0] sle_stat_byte(input sle_stat_t s);
    sle_stat_byte = {s.not_ready, 1'b0, s.edge_count_fault_flag, 1'b0, s.crc_fault,
                     s.readonly_write_flag, s.partial_access, s.invalid_address};
  endfunction

  // data bytes a register needs; zero marks an unmapped address
  function automatic logic [1:0] sle_reg_len(input logic [6:0] a);
    if (a == ADDR_STATUS || a == ADDR_ID || a == ADDR_CONFIG) begin
      sle_reg_len = 2'd1;
    end else if (a == ADDR_SCRATCH) begin
      sle_reg_len = 2'd2;
    end else begin
      sle_reg_len = 2'd0;
    end
  endfunction

  // msb-first crc over one byte
  function automatic logic [7:0] sle_crc8(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    sle_crc8 = c;
  endfunction

endpackage

// ---- hdl/sle_link_regs.sv ----
// Purpose: serial link slave with link error flags and misc link configuration
// Assumes: mode 0 msb first framing; cs_n high between frames; sclk idle then
// Notes:   address byte (bit 7 read), dummy byte on reads, data high first,
//          optional crc byte; writes land at the end of a clean frame

// Overview of operation
// - frame ending mid-byte sets the edge count fault flag, bit 5
// - error flags stay set until the host writes one to them
// - missing or wrong crc byte sets status bit 3
// - write to the read-only register sets status bit 2
// - too few data bytes for a multibyte register sets status bit 1
// - frame to an unmapped address sets status bit 0
// - all flags reset to zero; status bit 4 is reserved, reads zero
// - configuration register lives at 0x14, resets to 0x04
// - configuration bit 6 enables the alert pin pull-up, resets zero
// - configuration bit 4 enables background memory crc checking
// - configuration bits 3:2 select data pin drive strength, reset 01
// - configuration bit 0 selects double data rate transfers
// - configuration bits 7, 5, 1 are reserved, zero, not writable
// - frame started before the interface is ready sets status bit 7
// - status register lives at 0x11, resets to 0x00
module sle_link_regs #(
  parameter logic [7:0]  ID_VALUE     = sle_pkg::ID_DEFAULT,  // arbitrary value
  parameter int unsigned READY_CYCLES = sle_pkg::READY_CYCLES
) (
  // system clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // serial link pins
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          sdi,
  output logic               sdo,
  output logic               sdo_oe,
  // frame option from the neighbouring interface logic
  input  wire logic          crc_enable,
  // register contents towards the rest of the device
  output sle_pkg::sle_cfg_t  link_cfg,
  output sle_pkg::sle_stat_t link_flags
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (READY_CYCLES < 1 || READY_CYCLES > 65535) begin : g_bad_ready
    $error("READY_CYCLES must be 1 to 65535");
  end

  localparam logic [15:0] READY_LAST = 16'(READY_CYCLES);

  // ----------------------------------------------------------------
  // link side, clocked by sclk
  // ----------------------------------------------------------------
  logic       first_q;
  logic [2:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [6:0] rx_shift;
  logic [7:0] rx_hold;
  logic       rx_toggle;
  logic       rd_flag;
  logic       mid_byte;
  logic [6:0] tx_shift;
  logic [15:0] rd_word;

  wire        link_clr     = cs_n | ~rst_n;
  wire [2:0]  next_bit_cnt = first_q ? 3'd1 : bit_cnt + 3'd1;
  wire        byte_done    = (next_bit_cnt == 3'd0);
  wire [7:0]  rx_byte      = {rx_shift, sdi};
  // rd_word is settled by the system side long before these bytes start
  wire        tx_load      = !first_q && bit_cnt == 3'd0 && rd_flag &&
                             (byte_idx == 3'd2 || byte_idx == 3'd3);
  wire [7:0]  tx_sel       = (byte_idx == 3'd2) ? rd_word[15:8] : rd_word[7:0];

  // marks the first edge of a frame; sclk is idle while cs_n is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // bit counter survives frame end so a short byte is still visible
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt  <= 3'd0;
      rx_shift <= 7'd0;
      mid_byte <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      rx_shift <= rx_byte[6:0];
      mid_byte <= !byte_done;
    end
  end

  // completed byte handed over by toggle
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold   <= 8'h00;
      rx_toggle <= 1'b0;
      rd_flag   <= 1'b0;
      byte_idx  <= 3'd0;
    end else if (byte_done) begin
      rx_hold   <= rx_byte;
      rx_toggle <= ~rx_toggle;
      rd_flag   <= (byte_idx == 3'd0) ? rx_byte[7] : rd_flag;
      byte_idx  <= (byte_idx == 3'd7) ? byte_idx : byte_idx + 3'd1;
    end else if (first_q) begin
      byte_idx  <= 3'd0;
    end
  end

  // read data launched on the falling edge, held off outside frames
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      sdo      <= 1'b0;
      tx_shift <= 7'd0;
      sdo_oe   <= 1'b0;
    end else if (tx_load) begin
      sdo      <= tx_sel[7];
      tx_shift <= tx_sel[6:0];
      sdo_oe   <= 1'b1;
    end else begin
      sdo      <= tx_shift[6];
      tx_shift <= {tx_shift[5:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------
  logic cs_meta, cs_sync, cs_prev, cs_old;
  logic tg_meta, tg_sync, tg_prev;
  logic mid_meta, mid_sync;

  // cs path one stage longer than byte path: last byte lands before frame end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {cs_meta, cs_sync, cs_prev, cs_old} <= 4'hF;
      {tg_meta, tg_sync, tg_prev}         <= 3'd0;
      {mid_meta, mid_sync}                <= 2'd0;
    end else begin
      {cs_meta, cs_sync, cs_prev, cs_old} <= {cs_n, cs_meta, cs_sync, cs_prev};
      {tg_meta, tg_sync, tg_prev}         <= {rx_toggle, tg_meta, tg_sync};
      {mid_meta, mid_sync}                <= {mid_byte, mid_meta};
    end
  end

  wire frame_start = cs_old & ~cs_prev;
  wire frame_end   = ~cs_old & cs_prev;
  wire byte_evt    = tg_sync ^ tg_prev;

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_WAIT, S_DATA, S_CRC, S_DONE, S_SKIP, S_BLOCK
  } sle_state_t;

  sle_state_t state, next_state;
  logic [15:0] ready_cnt;
  logic        is_read;
  logic [6:0]  addr;
  logic [1:0]  need;
  logic [1:0]  left;
  logic [15:0] wdata;
  logic [7:0]  crc;
  logic        crc_on;
  logic        crc_ok;
  logic [15:0] scratch;

  wire        ready    = (ready_cnt == READY_LAST);
  wire [1:0]  addr_len = sle_pkg::sle_reg_len(rx_hold[6:0]);
  wire [7:0]  wlow     = wdata[7:0];

  // read value chosen once the address byte is in
  function automatic logic [15:0] read_word(input logic [6:0] a);
    if (a == sle_pkg::ADDR_STATUS) begin
      read_word = {sle_pkg::sle_stat_byte(link_flags), 8'h00};
    end else if (a == sle_pkg::ADDR_CONFIG) begin
      read_word = {sle_pkg::sle_cfg_byte(link_cfg), 8'h00};
    end else if (a == sle_pkg::ADDR_ID) begin
      read_word = {ID_VALUE, 8'h00};
    end else if (a == sle_pkg::ADDR_SCRATCH) begin
      read_word = scratch;
    end else begin
      read_word = 16'h0000;
    end
  endfunction

  // next state; frame end always wins
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (frame_start) begin
        next_state = ready ? S_ADDR : S_BLOCK;
      end
      S_ADDR: if (byte_evt) begin
        next_state = (addr_len == 2'd0) ? S_SKIP : (rx_hold[7] ? S_WAIT : S_DATA);
      end
      S_WAIT: if (byte_evt) begin
        next_state = S_DATA;
      end
      S_DATA: if (byte_evt && left == 2'd1) begin
        next_state = crc_on ? S_CRC : S_DONE;
      end
      S_CRC: if (byte_evt) begin
        next_state = S_DONE;
      end
      default: next_state = state;
    endcase
    if (frame_end) begin
      next_state = S_IDLE;
    end
  end

  // ready delay after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_cnt <= 16'd0;
      state     <= S_IDLE;
    end else begin
      ready_cnt <= ready ? ready_cnt : ready_cnt + 16'd1;
      state     <= next_state;
    end
  end

  // frame fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {is_read, addr, need, left, wdata, rd_word} <= '0;
    end else if (state == S_ADDR && byte_evt) begin
      is_read <= rx_hold[7];
      addr    <= rx_hold[6:0];
      need    <= addr_len;
      left    <= addr_len;
      rd_word <= read_word(rx_hold[6:0]);
    end else if (state == S_DATA && byte_evt) begin
      wdata   <= {wdata[7:0], rx_hold};
      left    <= left - 2'd1;
    end
  end

  // running crc over every byte before the crc byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc    <= sle_pkg::CRC_INIT;
      crc_on <= 1'b0;
      crc_ok <= 1'b0;
    end else if (frame_start) begin
      crc    <= sle_pkg::CRC_INIT;
      crc_on <= crc_enable;
      crc_ok <= ~crc_enable;
    end else if (byte_evt) begin
      crc    <= sle_pkg::sle_crc8(crc, rx_hold);
      crc_ok <= (state == S_CRC) ? (rx_hold == crc) : crc_ok;
    end
  end

  // ----------------------------------------------------------------
  // error events and register updates
  // ----------------------------------------------------------------
  wire decoded     = state == S_WAIT || state == S_DATA || state == S_CRC || state == S_DONE;
  wire in_frame    = decoded || state == S_ADDR || state == S_SKIP;
  wire ev_edge     = frame_end && in_frame && mid_sync;
  wire ev_crc      = frame_end && decoded && crc_on && !crc_ok;
  wire ev_ro       = frame_end && decoded && !is_read && addr == sle_pkg::ADDR_ID;
  wire ev_partial  = frame_end && (state == S_WAIT || state == S_DATA) && need > 2'd1;
  wire ev_invalid  = frame_end && state == S_SKIP;
  wire ev_notready = frame_start && !ready;
  // a short, crc-failed or read frame never commits a register write
  wire commit      = frame_end && state == S_DONE && !is_read && !mid_sync && crc_ok;
  wire wr_status   = commit && addr == sle_pkg::ADDR_STATUS;
  wire wr_config   = commit && addr == sle_pkg::ADDR_CONFIG;

  wire sle_pkg::sle_stat_t flag_set = '{not_ready: ev_notready,
    edge_count_fault_flag: ev_edge, crc_fault: ev_crc, readonly_write_flag: ev_ro,
    partial_access: ev_partial, invalid_address: ev_invalid};
  // reserved bits 6 and 4 of the written byte are dropped
  wire sle_pkg::sle_stat_t flag_clr = wr_status ? sle_pkg::sle_stat_t'{not_ready: wlow[7],
    edge_count_fault_flag: wlow[5], crc_fault: wlow[3], readonly_write_flag: wlow[2],
    partial_access: wlow[1], invalid_address: wlow[0]} : '0;

  // sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_flags <= '0;
    end else begin
      link_flags <= (link_flags & ~flag_clr) | flag_set;
    end
  end

  // configuration and scratch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_cfg <= sle_pkg::sle_cfg_from(sle_pkg::CONFIG_RESET);
      scratch  <= sle_pkg::SCRATCH_RESET;
    end else begin
      link_cfg <= wr_config ? sle_pkg::sle_cfg_from(wlow) : link_cfg;
      scratch  <= (commit && addr == sle_pkg::ADDR_SCRATCH) ? wdata : scratch;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire [7:0] stat_byte = sle_pkg::sle_stat_byte(link_flags);
  wire [7:0] cfg_byte  = sle_pkg::sle_cfg_byte(link_cfg);

  reserved_zero_a: assert property (
    stat_byte[6] == 1'b0 && stat_byte[4] == 1'b0 &&
    cfg_byte[7] == 1'b0 && cfg_byte[5] == 1'b0 && cfg_byte[1] == 1'b0)
    else $error("reserved bit reads as one");

  reset_values_a: assert property (
    !ready |-> cfg_byte == sle_pkg::CONFIG_RESET && stat_byte[6:0] == 7'd0)
    else $error("register left its reset value before ready");

  w1c_clear_a: assert property (
    wr_status && wlow[5] && !ev_edge |=> !link_flags.edge_count_fault_flag)
    else $error("write one did not clear edge count flag");

  sticky_hold_a: assert property (
    link_flags.crc_fault && !(wr_status && wlow[3]) |=> link_flags.crc_fault)
    else $error("crc flag dropped without a write one");

  edge_flag_a: assert property (
    frame_end && in_frame && mid_sync |=> link_flags.edge_count_fault_flag)
    else $error("short byte not flagged");

  crc_flag_a: assert property (
    frame_end && crc_on && (state == S_DATA || state == S_CRC) |=> link_flags.crc_fault)
    else $error("missing crc not flagged");

  ro_write_a: assert property (
    frame_end && state == S_DONE && !is_read && addr == sle_pkg::ADDR_ID
    |=> link_flags.readonly_write_flag) else $error("read-only write not flagged");

  partial_flag_a: assert property (
    frame_end && state == S_DATA && addr == sle_pkg::ADDR_SCRATCH
    |=> link_flags.partial_access)
    else $error("partial access not flagged");

  invalid_addr_a: assert property (
    state == S_ADDR && byte_evt && addr_len == 2'd0 && !frame_end |=> state == S_SKIP)
    else $error("invalid address frame lost");

  invalid_flag_a: assert property (
    frame_end && state == S_SKIP |=> link_flags.invalid_address)
    else $error("invalid address not flagged");

  not_ready_a: assert property (
    frame_start && !ready |=> link_flags.not_ready && state == S_BLOCK)
    else $error("early frame not flagged");

  cfg_write_a: assert property (
    wr_config |=> link_cfg == sle_pkg::sle_cfg_from($past(wlow)))
    else $error("configuration write not applied");

  write_commit_c: cover property (wr_config);
  read_frame_c:   cover property (frame_end && state == S_DONE && is_read);
  crc_error_c:    cover property (ev_crc);
  early_frame_c:  cover property (ev_notready);

endmodule

// ---- dv/sle_host_model.sv ----
// Purpose: host model that drives register frames onto the serial link
// Assumes: mode 0, msb first, sclk low and still between frames
// Notes:   keeps its own crc so that a slip shared with the device stays visible
module sle_host_model (
  // serial link towards the device
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  // read data back from the device
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic oe_seen;  // device drove the data pin in the last frame

  // crc-8, poly 07, init zero, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    return r;
  endfunction

  // idle: no frame, clock parked low
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    sdi     = 1'b0;
    oe_seen = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame: crc_mode 0 none, 1 correct, 2 corrupted
  // ----------------------------------------------------------------
  task automatic xfer(input logic [23:0] data, input int nbytes, input int extra,
                      input int crc_mode, output logic [7:0] rd);
    logic [31:0] bits;
    logic [7:0]  crc;
    int          total;
    crc  = 8'h00;
    bits = {data, 8'h00};
    for (int k = 0; k < nbytes; k++) begin
      crc = crc_step(crc, data[23-8*k -: 8]);
    end
    if (crc_mode != 0) begin
      bits[31-8*nbytes -: 8] = (crc_mode == 2) ? ~crc : crc;
    end
    total   = 8 * nbytes + extra + ((crc_mode != 0) ? 8 : 0);
    rd      = 8'h00;
    oe_seen = 1'b0;
    #7;
    cs_n = 1'b0;
    for (int i = 0; i < total; i++) begin
      sdi = bits[31-i];
      #15;
      sclk = 1'b1;
      // third byte carries the register contents on a read
      if (i >= 16 && i < 24) begin
        rd = {rd[6:0], sdo};
      end
      oe_seen = oe_seen | sdo_oe;
      #15;
      sclk = 1'b0;
    end
    // keep cs_n low well past the last rising edge before closing
    #120;
    cs_n = 1'b1;
    sdi  = ~sdi;  // released line: do not leave the last bit standing
    #400;
  endtask
endmodule

// ---- dv/spi_link_error_and_config_regs_tb.sv ----
// Purpose: self-checking bench for the link error flags and config register
// Assumes: short ready count, frames driven by the host model
// Notes:   every fault is raised and cleared; all but not-ready are first held against a write of the flag's complement
module spi_link_error_and_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic        ce;
    logic [23:0] d;
    int          n;
    int          extra;
    int          mode;
    logic [7:0]  flag;
  } sle_fault_t;

  localparam int unsigned READY = 12;

  logic               clock;
  logic               rst_n;
  logic               crc_enable;
  logic               sclk;
  logic               cs_n;
  logic               sdi;
  logic               sdo;
  logic               sdo_oe;
  logic [7:0]         rd;
  sle_pkg::sle_cfg_t  link_cfg;
  sle_pkg::sle_stat_t link_flags;
  int                 fails;
  int                 tests_run;
  logic [8:0]         cfg_rows [6];
  sle_fault_t         fault_rows [6];

  sle_link_regs #(.READY_CYCLES(READY)) DUT (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .crc_enable(crc_enable), .link_cfg(link_cfg), .link_flags(link_flags)
  );

  sle_host_model host (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  // 20 MHz system clock
  initial clock = 1'b0;
  always #25 clock = ~clock;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // config byte as the four stored fields
  function automatic logic [7:0] cfg_img(input logic [7:0] b);
    return {3'b000, b[6], b[4], b[3:2], b[0]};
  endfunction

  // status byte as the six stored flags
  function automatic logic [7:0] flag_img(input logic [7:0] b);
    return {2'b00, b[7], b[5], b[3:0]};
  endfunction

  // crc_enable moves on the falling clock edge, before cs_n falls
  task automatic frame(input logic ce, input logic [23:0] d, input int n, input int extra,
                       input int mode);
    @(negedge clock);
    crc_enable = ce;
    host.xfer(d, n, extra, mode, rd);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    frame(1'b0, {1'b0, a, v, 8'h00}, 2, 0, 0);
  endtask

  task automatic rdreg(input logic [6:0] a);
    frame(1'b0, {1'b1, a, 8'h00, 8'h00}, 3, 0, 0);
  endtask

  // hang guard
  initial begin
    #200_000;
    fails++;
    $display("ERROR watchdog expired");
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fails      = 0;
    tests_run  = 0;
    rst_n      = 1'b0;
    crc_enable = 1'b0;
    // bit 8 asks for a correct crc byte
    cfg_rows = '{9'h0FF, 9'h000, 9'h008, 9'h00C, 9'h151, 9'h004};
    fault_rows = '{
      '{1'b0, {8'h12, 8'h33, 8'h00}, 2, 0, 0, 8'h04},
      '{1'b0, {8'h18, 8'hAB, 8'h00}, 2, 0, 0, 8'h02},
      '{1'b0, {8'h20, 8'h11, 8'h00}, 2, 0, 0, 8'h01},
      '{1'b0, {8'h14, 8'hF0, 8'h00}, 1, 4, 0, 8'h20},
      '{1'b1, {8'h14, 8'h5D, 8'h00}, 2, 0, 0, 8'h08},
      '{1'b1, {8'h14, 8'h00, 8'h00}, 2, 0, 2, 8'h08}};
    repeat (16) @(negedge clock);
    check("cfg_rst", {3'b000, link_cfg}, cfg_img(8'h04));
    check("flags_rst", {2'b00, link_flags}, 8'h00);
    check("oe_rst", {7'h00, sdo_oe}, 8'h00);
    rst_n = 1'b1;
    // frame too early after release is dropped and flagged
    wr(7'h14, 8'h51);
    check("early_flag", {2'b00, link_flags}, flag_img(8'h80));
    check("early_cfg", {3'b000, link_cfg}, cfg_img(8'h04));
    wr(7'h11, 8'h80);
    check("early_clr", {2'b00, link_flags}, 8'h00);
    // ordinary config writes, each read back over the link
    foreach (cfg_rows[i]) begin
      frame(cfg_rows[i][8], {8'h14, cfg_rows[i][7:0], 8'h00}, 2, 0, cfg_rows[i][8] ? 1 : 0);
      check("cfg_out", {3'b000, link_cfg}, cfg_img(cfg_rows[i][7:0]));
      rdreg(7'h14);
      check("cfg_read", rd, cfg_rows[i][7:0] & 8'h5D);
      check("oe_seen", {7'h00, host.oe_seen}, 8'h01);
      check("oe_idle", {7'h00, sdo_oe}, 8'h00);
    end
    // full two-byte access raises nothing; read-only register reads back
    frame(1'b0, {8'h18, 8'hAB, 8'hCD}, 3, 0, 0);
    check("full_access", {2'b00, link_flags}, 8'h00);
    rdreg(7'h12);
    check("id_read", rd, sle_pkg::ID_DEFAULT);
    // each fault: set, survive a write of its complement, clear with a one
    foreach (fault_rows[i]) begin
      frame(fault_rows[i].ce, fault_rows[i].d, fault_rows[i].n, fault_rows[i].extra,
            fault_rows[i].mode);
      check("fault_flag", {2'b00, link_flags}, flag_img(fault_rows[i].flag));
      check("fault_cfg", {3'b000, link_cfg}, cfg_img(8'h04));
      rdreg(7'h11);
      check("status_read", rd, fault_rows[i].flag);
      wr(7'h11, ~fault_rows[i].flag);
      check("flag_kept", {2'b00, link_flags}, flag_img(fault_rows[i].flag));
      wr(7'h11, fault_rows[i].flag);
      check("flag_clr", {2'b00, link_flags}, 8'h00);
    end
    // mid-run reset drops a raised flag, a short byte and the config
    wr(7'h14, 8'h5D);
    frame(1'b0, {8'h14, 8'hF0, 8'h00}, 1, 4, 0);
    check("pre_rst", {2'b00, link_flags}, flag_img(8'h20));
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    check("cfg_rst2", {3'b000, link_cfg}, cfg_img(8'h04));
    check("flags_rst2", {2'b00, link_flags}, 8'h00);
    rst_n = 1'b1;
    repeat (READY + 5) @(negedge clock);
    wr(7'h14, 8'h10);
    check("cfg_after_rst", {3'b000, link_cfg}, cfg_img(8'h10));
    check("flags_after_rst", {2'b00, link_flags}, 8'h00);
    test_done();
  end
endmodule
